/* core/npc_codec.sv */
`timescale 1ns/10ps
// Operation
// (RQ1) Packet 24: three position deviations, 12 bytes
// (RQ2) Packet 25: three velocity deviations, 12 bytes
// (RQ3) Packet 26: roll, pitch, heading deviations
// (RQ4) Packet 27: four quaternion deviations, 16 bytes
// (RQ5) Packet 28: twelve raw sensor floats, 48 bytes
// (RQ6) Packet 29: 74 bytes, time words first
// (RQ7) Packet 29: doubles at 8-24, velocities 32-40
// (RQ8) Packet 29: deviations, tilt, heading; status at 72
// (RQ9) Receiver position and velocity pass unchanged
// (RQ10) Status bits 0-2 hold fix code
// (RQ11) Status flags bits 3-8, bits 9-15 zero
// (RQ12) Packet 30: dilutions then five satellite counts
// (RQ13) Packet 31 length is seven per satellite
// (RQ14) Seven-byte satellite record layout, back to back
// (RQ15) Fix codes zero through seven defined
// (RQ16) Satellite system codes zero through nine
// (RQ17) Frequency byte is an eight-bit band mask
// (RQ18) Multi-byte fields go least significant byte first
// (RQ19) Receiver discards payloads of wrong length; the host model keeps them and only sets len_bad
module npc_codec (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic pkt_start,
  input wire logic [7:0] pkt_id,
  input wire logic pkt_send,
  input wire logic fld_wr,
  input wire logic [4:0] fld_idx,
  input wire logic [63:0] fld_data,
  input wire npc_pkg::npc_fix_t fix_type,
  input wire logic doppler_ok,
  input wire logic time_ok,
  input wire logic ext_rcvr,
  input wire logic tilt_ok,
  input wire logic heading_ok,
  input wire logic float_amb,
  input wire logic sat_wr,
  input wire logic [7:0] sat_system,
  input wire logic [7:0] sat_prn,
  input wire logic [7:0] sat_freq,
  input wire logic [7:0] sat_elev,
  input wire logic [15:0] sat_azim,
  input wire logic [7:0] sat_snr,
  input wire logic out_ready,
  output logic out_valid,
  output logic [7:0] out_byte,
  output logic out_last,
  output logic [7:0] out_len,
  output logic [7:0] out_pid,
  output logic pkt_open,
  output logic pkt_done,
  output logic id_err,
  output logic fld_err,
  output logic sat_err
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    npc_pkg::npc_state_t state;
    logic [npc_pkg::BUF_BYTES-1:0][7:0] pay;
    logic [7:0] pid;
    logic [7:0] len;
    logic [7:0] ptr;
    logic [5:0] nsat;
    logic open;
    logic valid;
    logic [7:0] obyte;
    logic last;
    logic done;
    logic id_err;
    logic fld_err;
    logic sat_err;
  } npc_regs_t;

  // Field placement: valid flag, byte size and byte offset.
  typedef struct packed {
    logic ok;
    logic [3:0] size;
    logic [7:0] off;
  } npc_map_t;

  npc_regs_t regs_ff;
  npc_regs_t nxt_regs;
  npc_map_t fmap;
  logic [15:0] status_word;
  logic [npc_pkg::REC_BITS-1:0] rec;
  logic rec_bad;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Payload length fixed by each identifier; the detail packet grows with records.
  function automatic logic [7:0] len_of(input logic [7:0] pid);
    case (pid)
      npc_pkg::ID_POS_SD: len_of = npc_pkg::LEN_SD3; // RQ1
      npc_pkg::ID_VEL_SD: len_of = npc_pkg::LEN_SD3; // RQ2
      npc_pkg::ID_EULER_SD: len_of = npc_pkg::LEN_SD3; // RQ3
      npc_pkg::ID_QUAT_SD: len_of = npc_pkg::LEN_QUAT_SD; // RQ4
      npc_pkg::ID_RAW_SENS: len_of = npc_pkg::LEN_RAW_SENS; // RQ5
      npc_pkg::ID_RAW_RCVR: len_of = npc_pkg::LEN_RAW_RCVR; // RQ6
      npc_pkg::ID_SATS: len_of = npc_pkg::LEN_SATS; // RQ12
      default: len_of = npc_pkg::LEN_EMPTY; // RQ13
    endcase
  endfunction

  // Maps a field number of the open packet to its size and byte offset.
  function automatic npc_map_t field_map(input logic [7:0] pid, input logic [4:0] idx);
    npc_map_t m;
    m = '0;
    case (pid)
      npc_pkg::ID_POS_SD, npc_pkg::ID_VEL_SD, npc_pkg::ID_EULER_SD: begin
        m.ok = (idx < npc_pkg::NF_SD3); // RQ1 RQ2 RQ3
        m.size = npc_pkg::SZ_F32;
        m.off = {1'b0, idx, 2'b00};
      end
      npc_pkg::ID_QUAT_SD: begin
        m.ok = (idx < npc_pkg::NF_QUAT_SD); // RQ4
        m.size = npc_pkg::SZ_F32;
        m.off = {1'b0, idx, 2'b00};
      end
      npc_pkg::ID_RAW_SENS: begin
        m.ok = (idx < npc_pkg::NF_RAW_SENS); // RQ5
        m.size = npc_pkg::SZ_F32;
        m.off = {1'b0, idx, 2'b00};
      end
      npc_pkg::ID_RAW_RCVR: begin
        m.ok = (idx < npc_pkg::NF_RAW_RCVR);
        if (idx < npc_pkg::NF_RCVR_U32) begin
          m.size = npc_pkg::SZ_F32; // RQ6
          m.off = {1'b0, idx, 2'b00};
        end else if (idx < npc_pkg::NF_RCVR_F64) begin
          m.size = npc_pkg::SZ_F64; // RQ7
          m.off = npc_pkg::OFF_RCVR_F64 + {idx - npc_pkg::NF_RCVR_U32, 3'b000};
        end else begin
          m.size = npc_pkg::SZ_F32; // RQ7 RQ8
          m.off = npc_pkg::OFF_RCVR_F32 + {1'b0, idx - npc_pkg::NF_RCVR_F64, 2'b00};
        end
      end
      npc_pkg::ID_SATS: begin
        m.ok = (idx < npc_pkg::NF_SATS); // RQ12
        if (idx < npc_pkg::NF_SATS_F32) begin
          m.size = npc_pkg::SZ_F32;
          m.off = {1'b0, idx, 2'b00};
        end else begin
          m.size = npc_pkg::SZ_U8;
          m.off = npc_pkg::OFF_SATS_COUNTS + {3'b000, idx - npc_pkg::NF_SATS_F32};
        end
      end
      default: m = '0;
    endcase
    field_map = m;
  endfunction

  // ----------------------------------------------------------------
  // Packers
  // ----------------------------------------------------------------
  npc_status_pack u_status (
    .fix_type(fix_type),
    .doppler_ok(doppler_ok),
    .time_ok(time_ok),
    .ext_rcvr(ext_rcvr),
    .tilt_ok(tilt_ok),
    .heading_ok(heading_ok),
    .float_amb(float_amb),
    .status_word(status_word)
  );

  npc_sat_rec u_rec (
    .sat_system(sat_system),
    .sat_prn(sat_prn),
    .sat_freq(sat_freq),
    .sat_elev(sat_elev),
    .sat_azim(sat_azim),
    .sat_snr(sat_snr),
    .rec(rec),
    .rec_bad(rec_bad)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------

  // Start wins over send, send wins over field and record writes.
  always_comb begin
    nxt_regs = regs_ff;
    nxt_regs.done = 1'b0;
    nxt_regs.id_err = 1'b0;
    nxt_regs.fld_err = 1'b0;
    nxt_regs.sat_err = 1'b0;
    fmap = field_map(regs_ff.pid, fld_idx);
    case (regs_ff.state)
      npc_pkg::ST_IDLE, npc_pkg::ST_FILL: begin
        if (pkt_start) begin
          if (pkt_id >= npc_pkg::ID_POS_SD && pkt_id <= npc_pkg::ID_SAT_DETAIL) begin
            nxt_regs.state = npc_pkg::ST_FILL;
            nxt_regs.pay = '0;
            nxt_regs.pid = pkt_id;
            nxt_regs.len = len_of(pkt_id);
            nxt_regs.nsat = '0;
            nxt_regs.ptr = npc_pkg::PTR_RST;
            nxt_regs.open = 1'b1;
          end else begin
            nxt_regs.id_err = 1'b1;
          end
          nxt_regs.fld_err = fld_wr;
          nxt_regs.sat_err = sat_wr;
        end else if (pkt_send && regs_ff.state == npc_pkg::ST_FILL) begin
          if (regs_ff.pid == npc_pkg::ID_RAW_RCVR) begin
            nxt_regs.pay[npc_pkg::OFF_RCVR_STATUS] = status_word[7:0]; // RQ8 RQ18
            nxt_regs.pay[npc_pkg::OFF_RCVR_STATUS + 8'h01] = status_word[15:8]; // RQ8 RQ18
          end
          nxt_regs.open = 1'b0;
          nxt_regs.ptr = npc_pkg::PTR_RST;
          if (regs_ff.len == npc_pkg::LEN_EMPTY) begin
            nxt_regs.state = npc_pkg::ST_IDLE;
            nxt_regs.done = 1'b1;
          end else begin
            nxt_regs.state = npc_pkg::ST_SEND;
            nxt_regs.valid = 1'b1;
            nxt_regs.obyte = nxt_regs.pay[0];
            nxt_regs.last = (regs_ff.len == 8'h01);
          end
          nxt_regs.fld_err = fld_wr;
          nxt_regs.sat_err = sat_wr;
        end else begin
          // Field values are copied verbatim, low byte at the lowest offset.
          if (fld_wr) begin
            if (regs_ff.state == npc_pkg::ST_FILL && fmap.ok) begin
              for (int k = 0; k < 8; k++) begin
                if (k < int'(fmap.size)) begin
                  nxt_regs.pay[fmap.off + 8'(k)] = fld_data[8*k +: 8]; // RQ9 RQ18
                end
              end
            end else begin
              nxt_regs.fld_err = 1'b1;
            end
          end
          // Records are appended back to back after the last one.
          if (sat_wr) begin
            if (regs_ff.state == npc_pkg::ST_FILL && regs_ff.pid == npc_pkg::ID_SAT_DETAIL
                && regs_ff.nsat < npc_pkg::MAX_SATS && !rec_bad) begin
              for (int k = 0; k < 7; k++) begin
                nxt_regs.pay[regs_ff.len + 8'(k)] = rec[8*k +: 8]; // RQ14
              end
              nxt_regs.len = regs_ff.len + npc_pkg::REC_BYTES; // RQ13
              nxt_regs.nsat = regs_ff.nsat + 6'h01;
            end else begin
              nxt_regs.sat_err = 1'b1;
            end
          end
        end
      end
      npc_pkg::ST_SEND: begin
        // Writes during streaming are refused; starts are ignored.
        nxt_regs.fld_err = fld_wr;
        nxt_regs.sat_err = sat_wr;
        if (out_ready && regs_ff.valid) begin
          if (regs_ff.last) begin
            nxt_regs.state = npc_pkg::ST_IDLE;
            nxt_regs.valid = 1'b0;
            nxt_regs.last = 1'b0;
            nxt_regs.done = 1'b1;
          end else begin
            nxt_regs.ptr = regs_ff.ptr + 8'h01;
            nxt_regs.obyte = regs_ff.pay[regs_ff.ptr + 8'h01];
            nxt_regs.last = ((regs_ff.ptr + 8'h02) == regs_ff.len);
          end
        end
      end
      default: begin
        nxt_regs = '0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------

  // Synchronous active-low reset clears the whole state.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      regs_ff <= '0;
      regs_ff.state <= npc_pkg::ST_IDLE;
    end else begin
      regs_ff <= nxt_regs;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // Every output is a field of the state register.
  assign out_valid = regs_ff.valid;
  assign out_byte = regs_ff.obyte;
  assign out_last = regs_ff.last;
  assign out_len = regs_ff.len;
  assign out_pid = regs_ff.pid;
  assign pkt_open = regs_ff.open;
  assign pkt_done = regs_ff.done;
  assign id_err = regs_ff.id_err;
  assign fld_err = regs_ff.fld_err;
  assign sat_err = regs_ff.sat_err;

endmodule // npc_codec

/* core/npc_pkg.sv */
package npc_pkg;

  // ----------------------------------------------------------------
  // Packet identifiers and payload lengths
  // ----------------------------------------------------------------
  localparam logic [7:0] ID_POS_SD = 8'h18;
  localparam logic [7:0] ID_VEL_SD = 8'h19;
  localparam logic [7:0] ID_EULER_SD = 8'h1A;
  localparam logic [7:0] ID_QUAT_SD = 8'h1B;
  localparam logic [7:0] ID_RAW_SENS = 8'h1C;
  localparam logic [7:0] ID_RAW_RCVR = 8'h1D;
  localparam logic [7:0] ID_SATS = 8'h1E;
  localparam logic [7:0] ID_SAT_DETAIL = 8'h1F;

  localparam logic [7:0] LEN_SD3 = 8'h0C;
  localparam logic [7:0] LEN_QUAT_SD = 8'h10;
  localparam logic [7:0] LEN_RAW_SENS = 8'h30;
  localparam logic [7:0] LEN_RAW_RCVR = 8'h4A;
  localparam logic [7:0] LEN_SATS = 8'h0D;
  localparam logic [7:0] LEN_EMPTY = 8'h00;

  // ----------------------------------------------------------------
  // Field counts, sizes and offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] NF_SD3 = 5'h03;
  localparam logic [4:0] NF_QUAT_SD = 5'h04;
  localparam logic [4:0] NF_RAW_SENS = 5'h0C;
  localparam logic [4:0] NF_RCVR_U32 = 5'h02;
  localparam logic [4:0] NF_RCVR_F64 = 5'h05;
  localparam logic [4:0] NF_RAW_RCVR = 5'h0F;
  localparam logic [4:0] NF_SATS_F32 = 5'h02;
  localparam logic [4:0] NF_SATS = 5'h07;

  localparam logic [3:0] SZ_U8 = 4'h1;
  localparam logic [3:0] SZ_U16 = 4'h2;
  localparam logic [3:0] SZ_F32 = 4'h4;
  localparam logic [3:0] SZ_F64 = 4'h8;

  localparam logic [7:0] OFF_RCVR_F64 = 8'h08;
  localparam logic [7:0] OFF_RCVR_F32 = 8'h20;
  localparam logic [7:0] OFF_RCVR_STATUS = 8'h48;
  localparam logic [7:0] OFF_SATS_COUNTS = 8'h08;

  // ----------------------------------------------------------------
  // Satellite records
  // ----------------------------------------------------------------
  localparam logic [7:0] REC_BYTES = 8'h07;
  localparam int REC_BITS = 56;
  localparam logic [5:0] MAX_SATS = 6'h20;
  localparam int BUF_BYTES = 224;
  localparam int REC_SYS = 0;
  localparam int REC_PRN = 1;
  localparam int REC_FREQ = 2;
  localparam int REC_ELEV = 3;
  localparam int REC_AZIM = 4;
  localparam int REC_SNR = 6;
  localparam logic [7:0] SYS_LAST = 8'h09;

  typedef enum logic [7:0] {
    SYS_UNKNOWN = 8'h00, SYS_GPS = 8'h01, SYS_GLONASS = 8'h02, SYS_BEIDOU = 8'h03,
    SYS_GALILEO = 8'h04, SYS_SBAS = 8'h05, SYS_QZSS = 8'h06, SYS_CORR_A = 8'h07,
    SYS_CORR_B = 8'h08, SYS_IMES = 8'h09
  } npc_sys_t;

  // Frequency bitmask positions.
  localparam int FQ_L1_CA = 0;
  localparam int FQ_L1_C = 1;
  localparam int FQ_L1_P = 2;
  localparam int FQ_L1_M = 3;
  localparam int FQ_L2_C = 4;
  localparam int FQ_L2_P = 5;
  localparam int FQ_L2_M = 6;
  localparam int FQ_L5 = 7;

  // ----------------------------------------------------------------
  // Receiver status word
  // ----------------------------------------------------------------
  localparam int SW_FIX_LSB = 0;
  localparam int SW_DOPPLER = 3;
  localparam int SW_TIME = 4;
  localparam int SW_EXT_RCVR = 5;
  localparam int SW_TILT = 6;
  localparam int SW_HEADING = 7;
  localparam int SW_FLOAT_AMB = 8;
  localparam logic [15:0] SW_RESERVED_VAL = 16'h0000;

  typedef enum logic [2:0] {
    FIX_NONE = 3'h0, FIX_2D = 3'h1, FIX_3D = 3'h2, FIX_SBAS = 3'h3,
    FIX_DIFF = 3'h4, FIX_CORR = 3'h5, FIX_RTK_FLOAT = 3'h6, FIX_RTK_FIXED = 3'h7
  } npc_fix_t;

  typedef enum {ST_IDLE, ST_FILL, ST_SEND} npc_state_t;

  localparam logic [7:0] PTR_RST = 8'h00;

endpackage

/* core/npc_sat_rec.sv */
`timescale 1ns/10ps
module npc_sat_rec (
  input wire logic [7:0] sat_system,
  input wire logic [7:0] sat_prn,
  input wire logic [7:0] sat_freq,
  input wire logic [7:0] sat_elev,
  input wire logic [15:0] sat_azim,
  input wire logic [7:0] sat_snr,
  output logic [npc_pkg::REC_BITS-1:0] rec,
  output logic rec_bad
);

  // ----------------------------------------------------------------
  // Record image, least significant byte first
  // ----------------------------------------------------------------

  // Bytes are placed at their record offsets; the azimuth low byte goes first.
  always_comb begin
    rec = '0;
    rec[8*npc_pkg::REC_SYS +: 8] = sat_system; // RQ14
    rec[8*npc_pkg::REC_PRN +: 8] = sat_prn; // RQ14
    rec[8*npc_pkg::REC_FREQ +: 8] = sat_freq; // RQ14 RQ17
    rec[8*npc_pkg::REC_ELEV +: 8] = sat_elev; // RQ14
    rec[8*npc_pkg::REC_AZIM +: 8] = sat_azim[7:0]; // RQ18
    rec[8*(npc_pkg::REC_AZIM+1) +: 8] = sat_azim[15:8]; // RQ18
    rec[8*npc_pkg::REC_SNR +: 8] = sat_snr; // RQ14
  end

  // A system code beyond the defined set is refused by the framer.
  assign rec_bad = (sat_system > npc_pkg::SYS_LAST); // RQ16

endmodule // npc_sat_rec

/* core/npc_status_pack.sv */
`timescale 1ns/10ps
module npc_status_pack (
  input wire npc_pkg::npc_fix_t fix_type,
  input wire logic doppler_ok,
  input wire logic time_ok,
  input wire logic ext_rcvr,
  input wire logic tilt_ok,
  input wire logic heading_ok,
  input wire logic float_amb,
  output logic [15:0] status_word
);

  // ----------------------------------------------------------------
  // Status word assembly
  // ----------------------------------------------------------------

  // Fix code in the low three bits, flags above, upper bits forced to zero.
  always_comb begin
    status_word = npc_pkg::SW_RESERVED_VAL; // RQ11
    status_word[npc_pkg::SW_FIX_LSB +: 3] = fix_type; // RQ10 RQ15
    status_word[npc_pkg::SW_DOPPLER] = doppler_ok; // RQ11
    status_word[npc_pkg::SW_TIME] = time_ok; // RQ11
    status_word[npc_pkg::SW_EXT_RCVR] = ext_rcvr; // RQ11
    status_word[npc_pkg::SW_TILT] = tilt_ok; // RQ11
    status_word[npc_pkg::SW_HEADING] = heading_ok; // RQ11
    status_word[npc_pkg::SW_FLOAT_AMB] = float_amb; // RQ11
  end

endmodule // npc_status_pack

/* tb/npc_codec_assertions.sv */
`timescale 1ns/10ps
module npc_codec_assertions (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic pkt_start,
  input wire logic [7:0] pkt_id,
  input wire logic pkt_send,
  input wire logic fld_wr,
  input wire logic sat_wr,
  input wire logic [7:0] sat_system,
  input wire logic out_ready,
  input wire logic out_valid,
  input wire logic [7:0] out_byte,
  input wire logic out_last,
  input wire logic [7:0] out_len,
  input wire logic [7:0] out_pid,
  input wire logic pkt_open,
  input wire logic pkt_done,
  input wire logic fld_err,
  input wire logic sat_err
);
  logic [7:0] beats_ff;

  // Counts bytes the sink has taken since the packet was closed.
  always_ff @(posedge core_clk) begin
    if (!rst_b || (pkt_send && pkt_open)) begin
      beats_ff <= 8'h00;
    end else if (out_valid && out_ready) begin
      beats_ff <= beats_ff + 8'h01;
    end
  end

  // Payload length that belongs to each identifier.
  function automatic logic [7:0] len_of(input logic [7:0] id);
    case (id)
      8'h18, 8'h19, 8'h1A: return 8'h0C;
      8'h1B: return 8'h10;
      8'h1C: return 8'h30;
      8'h1D: return 8'h4A;
      8'h1E: return 8'h0D;
      default: return 8'h00;
    endcase
  endfunction

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  // Steps of a packet: open, record writes, close, final byte.
  sequence s_good_start;
    pkt_start && !out_valid && pkt_id >= 8'h18 && pkt_id <= 8'h1F;
  endsequence
  sequence s_rec_write;
    sat_wr && pkt_open && !pkt_start && !pkt_send && !out_valid;
  endsequence
  sequence s_take_send;
    pkt_send && pkt_open && !pkt_start;
  endsequence
  sequence s_last_take;
    out_valid && out_ready && out_last;
  endsequence

  a_open_len: assert property (
    s_good_start |=> pkt_open && out_pid == $past(pkt_id) && out_len == len_of($past(pkt_id))
  ) else $error("packet open, identifier or length wrong");
  a_rec_len_grow: assert property (
    s_rec_write ##0 (out_pid == 8'h1F && sat_system <= 8'h09 && out_len < 8'hE0)
      |=> out_len == $past(out_len) + 8'h07
  ) else $error("record did not add seven bytes");
  a_sat_sys_bad: assert property (
    s_rec_write ##0 (sat_system > 8'h09) |=> sat_err
  ) else $error("unknown system code accepted");
  a_send_streams: assert property (
    s_take_send |=> !pkt_open && (out_valid || pkt_done)
  ) else $error("send did not start the stream");
  a_byte_hold: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_byte) && $stable(out_last)
  ) else $error("byte changed while stalled");
  a_last_done: assert property (
    s_last_take |=> pkt_done && !out_valid
  ) else $error("no done after final byte");
  a_beat_count: assert property (
    s_last_take |-> beats_ff + 8'h01 == out_len
  ) else $error("byte count differs from length");
  a_fld_refused: assert property (
    fld_wr && !pkt_open |=> fld_err
  ) else $error("field write without packet not refused");
endmodule  // npc_codec_assertions

bind npc_codec npc_codec_assertions chk_u (
  .core_clk(core_clk), .rst_b(rst_b), .pkt_start(pkt_start), .pkt_id(pkt_id),
  .pkt_send(pkt_send), .fld_wr(fld_wr), .sat_wr(sat_wr), .sat_system(sat_system),
  .out_ready(out_ready), .out_valid(out_valid), .out_byte(out_byte), .out_last(out_last),
  .out_len(out_len), .out_pid(out_pid), .pkt_open(pkt_open), .pkt_done(pkt_done),
  .fld_err(fld_err), .sat_err(sat_err)
);

/* tb/npc_codec_bench.sv */
`timescale 1ns/10ps
module npc_codec_bench;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic pkt_start = 1'b0;
  logic [7:0] pkt_id = 8'h00;
  logic pkt_send = 1'b0;
  logic fld_wr = 1'b0;
  logic [4:0] fld_idx = 5'h00;
  logic [63:0] fld_data = 64'h0;
  npc_pkg::npc_fix_t fix_type = npc_pkg::FIX_NONE;
  logic [5:0] flags = 6'h00;
  logic sat_wr = 1'b0;
  logic [55:0] srec = 56'h0;
  logic stall = 1'b0;
  logic out_ready, out_valid, out_last, pkt_open, pkt_done, id_err, fld_err, sat_err;
  logic [7:0] out_byte, out_len, out_pid;
  logic [7:0] exp_b [0:223];
  int exp_len, n_fail = 0, n_compared = 0;

  // Record bytes sit in srec in payload order, flags in status bit order.
  npc_codec dut_u (
    .core_clk(core_clk), .rst_b(rst_b), .pkt_start(pkt_start), .pkt_id(pkt_id),
    .pkt_send(pkt_send), .fld_wr(fld_wr), .fld_idx(fld_idx), .fld_data(fld_data),
    .fix_type(fix_type), .doppler_ok(flags[0]), .time_ok(flags[1]), .ext_rcvr(flags[2]),
    .tilt_ok(flags[3]), .heading_ok(flags[4]), .float_amb(flags[5]), .sat_wr(sat_wr),
    .sat_system(srec[7:0]), .sat_prn(srec[15:8]), .sat_freq(srec[23:16]),
    .sat_elev(srec[31:24]), .sat_azim(srec[47:32]), .sat_snr(srec[55:48]),
    .out_ready(out_ready), .out_valid(out_valid), .out_byte(out_byte), .out_last(out_last),
    .out_len(out_len), .out_pid(out_pid), .pkt_open(pkt_open), .pkt_done(pkt_done),
    .id_err(id_err), .fld_err(fld_err), .sat_err(sat_err)
  );
  npc_host_model host_u (
    .core_clk(core_clk), .rst_b(rst_b), .stall(stall), .clear(pkt_send), .out_valid(out_valid),
    .out_byte(out_byte), .out_last(out_last), .out_pid(out_pid), .out_ready(out_ready)
  );

  // Clock at 125 MHz.
  initial begin
    forever #4 core_clk = ~core_clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Counts one comparison and reports it when it fails.
  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (!ok) begin
      n_fail++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask

  // Byte offset and size of a field in the packet layouts.
  function automatic int f_off(input int id, input int idx);
    if (id == 29 && idx >= 5) return 32 + 4 * (idx - 5);
    if (id == 29 && idx >= 2) return 8 + 8 * (idx - 2);
    if (id == 30 && idx >= 2) return 6 + idx;
    return 4 * idx;
  endfunction
  function automatic int f_size(input int id, input int idx);
    if (id == 29 && idx >= 2 && idx < 5) return 8;
    if (id == 30 && idx >= 2) return 1;
    return 4;
  endfunction

  // Opens a packet and clears the expected payload.
  task automatic open_pkt(input logic [7:0] id, input int len);
    @(negedge core_clk);
    pkt_start = 1'b1;
    pkt_id = id;
    @(negedge core_clk);
    pkt_start = 1'b0;
    chk(pkt_open === 1'b1 && out_len === 8'(len) && out_pid === id, "open state");
    exp_len = len;
    for (int i = 0; i < 224; i++) exp_b[i] = 8'h00;
  endtask

  // Writes one field; an accepted one lands least significant byte first.
  task automatic wr_fld(input int id, input int idx, input logic err);
    logic [63:0] d;
    d = {48'hC3A5_96F0_1E2D, 8'(id), 8'(idx)};
    @(negedge core_clk);
    fld_wr = 1'b1;
    fld_idx = 5'(idx);
    fld_data = d;
    @(negedge core_clk);
    fld_wr = 1'b0;
    chk(fld_err === err, "field refusal flag");
    if (!err) begin
      for (int b = 0; b < f_size(id, idx); b++) exp_b[f_off(id, idx) + b] = d[8*b +: 8];
    end
  endtask

  // Appends one satellite record unless it is expected to be refused.
  task automatic wr_sat(input logic [55:0] r, input logic err);
    @(negedge core_clk);
    sat_wr = 1'b1;
    srec = r;
    @(negedge core_clk);
    sat_wr = 1'b0;
    if (!err) begin
      for (int b = 0; b < 7; b++) exp_b[exp_len + b] = r[8*b +: 8];
      exp_len += 7;
    end
    chk(sat_err === err && out_len === 8'(exp_len), "record flag or length");
  endtask

  // Closes the packet and compares what the host received.
  task automatic send_chk(input logic stl);
    @(negedge core_clk);
    stall = stl;
    pkt_send = 1'b1;
    @(negedge core_clk);
    pkt_send = 1'b0;
    for (int k = 0; k < 999 && pkt_done !== 1'b1; k++) @(negedge core_clk);
    chk(pkt_done === 1'b1 && host_u.n_got == exp_len, "stream length");
    chk(out_len === 8'(exp_len) && host_u.len_bad === 1'b0, "host length check");
    for (int i = 0; i < exp_len; i++) chk(host_u.got[i] === exp_b[i], "payload byte");
  endtask

  // Fills every field of a fixed packet, tries one index too many, then sends.
  task automatic t_fixed(input int id, input int len, input int nf, input logic stl);
    logic [15:0] st;
    st = {7'h00, flags, fix_type};
    open_pkt(8'(id), len);
    for (int i = 0; i <= nf; i++) wr_fld(id, i, i == nf);
    if (id == 29) begin
      exp_b[72] = st[7:0];
      exp_b[73] = st[15:8];
    end
    send_chk(stl);
    $display("test packet %0d done", id);
  endtask

  // Empty and full detail packets, every system code and band bit.
  task automatic t_sats();
    open_pkt(8'h1F, 0);
    send_chk(1'b0);
    open_pkt(8'h1F, 0);
    wr_fld(31, 0, 1'b1);
    wr_sat(56'h0A, 1'b1);
    for (int s = 0; s < 32; s++) begin
      wr_sat({8'(8'h30 + s), 16'(16'h1234 + 16'h0101 * s), 8'(8'h10 + s),
              8'(1 << (s % 8)), 8'(8'h40 + s), 8'(s % 10)}, 1'b0);
    end
    wr_sat(56'h01, 1'b1);
    send_chk(1'b1);
    $display("test detail packets done");
  endtask

  // Refused record, bad identifiers while open, unwritten fields, write when closed.
  task automatic t_refuse();
    open_pkt(8'h18, 12);
    wr_sat(56'h01, 1'b1);
    for (int i = 0; i < 2; i++) begin
      @(negedge core_clk);
      pkt_start = 1'b1;
      pkt_id = i ? 8'h20 : 8'h17;
      @(negedge core_clk);
      pkt_start = 1'b0;
      chk(id_err === 1'b1 && pkt_open === 1'b1, "bad identifier");
    end
    send_chk(1'b0);
    wr_fld(24, 0, 1'b1);
    $display("test refusals done");
  endtask

  // Main sequence.
  initial begin
    repeat (5) @(negedge core_clk);
    rst_b = 1'b1;
    @(negedge core_clk);
    chk(out_valid === 1'b0 && pkt_open === 1'b0 && out_len === 8'h00, "reset state");
    t_fixed(24, 12, 3, 1'b0);
    t_fixed(25, 12, 3, 1'b1);
    t_fixed(26, 12, 3, 1'b0);
    t_fixed(27, 16, 4, 1'b0);
    t_fixed(28, 48, 12, 1'b1);
    for (int f = 0; f < 8; f++) begin
      fix_type = npc_pkg::npc_fix_t'(f);
      flags = 6'(f * 11 + 5);
      t_fixed(29, 74, 15, f[0]);
    end
    t_fixed(30, 13, 7, 1'b0);
    t_sats();
    t_refuse();
    wrap_up();
  end

  // Watchdog well beyond the expected run time.
  initial begin
    #200000;
    n_fail++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    wrap_up();
  end
endmodule  // npc_codec_bench

/* tb/npc_host_model.sv */
`timescale 1ns/10ps
// Host receiver: takes payload bytes, can stall, and judges each length.
module npc_host_model (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic stall,
  input wire logic clear,
  input wire logic out_valid,
  input wire logic [7:0] out_byte,
  input wire logic out_last,
  input wire logic [7:0] out_pid,
  output logic out_ready
);
  logic [7:0] got [0:223];
  int n_got = 0;
  logic len_bad = 1'b0;
  logic [1:0] tick = 2'h0;

  // Ready moves after the falling edge; a stalling host is ready one cycle in four.
  initial out_ready = 1'b0;
  always @(negedge core_clk) begin
    tick <= tick + 2'h1;
    out_ready <= !stall || (tick == 2'h0);
  end

  // Clears on a close, stores each accepted byte, checks the length at the final byte.
  always @(posedge core_clk) begin
    if (clear) begin
      n_got <= 0;
      len_bad <= 1'b0;
    end
    if (rst_b && out_valid && out_ready) begin
      got[n_got] <= out_byte;
      n_got <= n_got + 1;
      if (out_last) begin
        case (out_pid)
          8'h18, 8'h19, 8'h1A: len_bad <= (n_got != 11);
          8'h1B: len_bad <= (n_got != 15);
          8'h1C: len_bad <= (n_got != 47);
          8'h1D: len_bad <= (n_got != 73);
          8'h1E: len_bad <= (n_got != 12);
          default: len_bad <= ((n_got + 1) % 7) != 0;
        endcase
      end
    end
  end
endmodule  // npc_host_model
